// *** core/cvc_top.sv ***
// Purpose: Core voltage control: bus target, command register, fault logic
// Assumes: Comparator results arrive as asynchronous levels; bus pins sampled
// Notes:   Reset stands in for power-on reset
//
// Functional notes
// - Slew code selects exactly one of four ramp current sources.
// - Slew code resets to 01, the 10 uA source.
// - Codes 00, 10, 11 select 5, 25, 47 uA sources.
// - Output above 112 percent for over 1.5 us flags overvoltage, three-states switch node.
// - Overvoltage clears only when output falls back to 106 percent.
// - Undervoltage flags below 88 percent, clears at 90 percent.
// - Overcurrent limits current; persisting undervoltage drops power good.
// - Power good low until all three outputs regulate, then released.
// - Power good follows fault state directly, never latched.
// - Battery good above 2.8 V, stays good until below 2.6 V.
// - One enable switches all three regulators together.
// - On address match target holds data low during ninth clock.
// - Each written byte is acknowledged low in ninth clock.
// - Bytes continue, separated by acknowledge, until stop or repeated start.
// - Written byte latched at acknowledge clock rise, applied at once.
// - Reference converter takes the 4-bit voltage code.
// - Read direction shifts command register out, one bit per clock.
// - Target works at standard and fast bus rates.
// - Voltage code maps 0.85 V to 1.6 V in 50 mV steps.
// - Select high turns bus pins plus two pins into code inputs.
// - Core target resets to 1.3 V under bus control.
// - Command register keeps codes while regulators are disabled.
`timescale 1ns/10ps
`default_nettype none
`include "cvc_consts.svh"

module cvc_top
    import cvc_pkg::*;
#(
    parameter logic [6:0] TGT_ADDR = 7'h2A,  // Arbitrary target address
    parameter int         OV_CYC   = `CVC_OV_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe_o,
    input  wire logic        vcode_b2_i,
    input  wire logic        vcode_b3_i,
    input  wire logic        code_source_select_i,
    input  wire logic        enable_i,
    input  wire logic        vout_over_set_i,
    input  wire logic        vout_over_hold_i,
    input  wire logic        vout_under_set_i,
    input  wire logic        vout_under_hold_i,
    input  wire logic        overcurrent_i,
    input  wire logic        memory_ldo_ok_i,
    input  wire logic        pll_ldo_ok_i,
    input  wire logic        batt_above_hi_i,
    input  wire logic        batt_below_lo_i,
    output var  logic        power_good_out_o,
    output var  logic        power_good_out_oe_o,
    output var  logic        battery_fault_n_o,
    output var  logic        regs_enable_o,
    output var  logic        phase_tristate_o,
    output var  logic        current_limit_o,
    output var  logic [3:0]  ramp_src_sel_o,
    output var  logic [3:0]  dac_code_o,
    output var  logic [10:0] vref_mv_o,
    output var  logic [7:0]  cmd_reg_o
);
    localparam int NS = 15;

    if (OV_CYC < 1 || OV_CYC > 65535) begin : g_chk
        $error("cvc_top: OV_CYC out of range");
    end

    // One-hot ramp source for a slew code
    function automatic logic [3:0] slew_onehot(input logic [1:0] code);
        slew_onehot = 4'h1 << code;
    endfunction : slew_onehot

    // Synchronised inputs
    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    logic          scl_s, sda_s, vb2_s, vb3_s, sel_s, en_s;
    logic          ovs_s, ovh_s, uvs_s, uvh_s, oc_s, mem_s, pll_s, bhi_s, blo_s;

    assign raw = {scl_i, sda_i, vcode_b2_i, vcode_b3_i, code_source_select_i,
                  enable_i, vout_over_set_i, vout_over_hold_i, vout_under_set_i,
                  vout_under_hold_i, overcurrent_i, memory_ldo_ok_i, pll_ldo_ok_i,
                  batt_above_hi_i, batt_below_lo_i};

    cvc_sync #(
        .W       (NS),
        .RST_VAL (15'h6000)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (raw),
        .sync_o  (syn)
    );

    assign {scl_s, sda_s, vb2_s, vb3_s, sel_s, en_s, ovs_s, ovh_s, uvs_s,
            uvh_s, oc_s, mem_s, pll_s, bhi_s, blo_s} = syn;

    // Fault monitors
    cvc_hyst_if ov_if ();
    cvc_hyst_if uv_if ();
    cvc_hyst_if bat_if ();

    assign ov_if.set  = ovs_s;
    assign ov_if.clr  = !ovh_s;
    assign uv_if.set  = uvs_s;
    assign uv_if.clr  = !uvh_s;
    assign bat_if.set = bhi_s;
    assign bat_if.clr = blo_s;

    cvc_hyst #(.SET_CYC(OV_CYC)) u_ov (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .mon    (ov_if)
    );

    cvc_hyst #(.SET_CYC(`CVC_UV_CYC)) u_uv (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .mon    (uv_if)
    );

    cvc_hyst #(.SET_CYC(1)) u_bat (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .mon    (bat_if)
    );

    // Bus edge detection state
    logic       scl_p_q, sda_p_q;
    logic       scl_rise, scl_fall, bus_start, bus_stop, bus_on;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Edge and framing events; the select pin turns the bus off
    always_comb begin
        bus_on    = !sel_s;
        scl_rise  = bus_on && scl_s && !scl_p_q;
        scl_fall  = bus_on && !scl_s && scl_p_q;
        bus_start = bus_on && scl_s && scl_p_q && !sda_s && sda_p_q;
        bus_stop  = bus_on && scl_s && scl_p_q && sda_s && !sda_p_q;
    end

    // Target state machine
    cvc_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic       rw_q, rw_d;
    logic       nack_q, nack_d;
    logic       oe_q, oe_d;
    logic [5:0] cmd_q, cmd_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        rw_d   = rw_q;
        nack_d = nack_q;
        oe_d   = oe_q;
        cmd_d  = cmd_q;                    // Held across disable
        if (!bus_on) begin
            st_d = CVC_ST_IDLE;
            oe_d = 1'b0;
        end else if (bus_start) begin      // Also repeated start
            st_d  = CVC_ST_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (bus_stop) begin
            st_d = CVC_ST_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                CVC_ST_ADDR, CVC_ST_WDAT: begin
                    sh_d  = {sh_q[6:0], sda_s};  // MSB first
                    cnt_d = cnt_q + 4'h1;
                end
                CVC_ST_RDAT: begin
                    cnt_d = cnt_q + 4'h1;
                end
                CVC_ST_WACK: begin
                    cmd_d = sh_q[`CVC_CMD_USED-1:0];
                end
                CVC_ST_RACK: begin
                    nack_d = sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_q)
                CVC_ST_ADDR: begin
                    if (cnt_q == `CVC_BITS_PER_BYTE) begin
                        if (sh_q[7:1] == TGT_ADDR) begin
                            st_d = CVC_ST_AACK;
                            rw_d = sh_q[0];
                            oe_d = 1'b1;
                        end else begin
                            st_d = CVC_ST_SKIP;
                        end
                    end
                end
                CVC_ST_AACK: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        st_d = CVC_ST_RDAT;
                        sh_d = {2'b00, cmd_q};
                        oe_d = 1'b1;               // Bit 7 is zero: pull low
                    end else begin
                        st_d = CVC_ST_WDAT;
                        oe_d = 1'b0;
                    end
                end
                CVC_ST_WDAT: begin
                    if (cnt_q == `CVC_BITS_PER_BYTE) begin
                        st_d = CVC_ST_WACK;
                        oe_d = 1'b1;
                    end
                end
                CVC_ST_WACK: begin
                    st_d  = CVC_ST_WDAT;
                    cnt_d = 4'h0;
                    oe_d  = 1'b0;
                end
                CVC_ST_RDAT: begin
                    if (cnt_q == `CVC_BITS_PER_BYTE) begin
                        st_d = CVC_ST_RACK;
                        oe_d = 1'b0;
                    end else begin
                        oe_d = !sh_q[6];
                        sh_d = {sh_q[6:0], 1'b0};
                    end
                end
                CVC_ST_RACK: begin
                    cnt_d = 4'h0;
                    if (nack_q) begin
                        st_d = CVC_ST_SKIP;
                    end else begin
                        st_d = CVC_ST_RDAT;
                        sh_d = {2'b00, cmd_q};
                        oe_d = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q   <= CVC_ST_IDLE;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            rw_q   <= 1'b0;
            nack_q <= 1'b0;
            oe_q   <= 1'b0;
            cmd_q  <= {`CVC_SLEW_DEF, `CVC_VCODE_DEF};
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            rw_q   <= rw_d;
            nack_q <= nack_d;
            oe_q   <= oe_d;
            cmd_q  <= cmd_d;
        end
    end

    // Output stage next values
    logic [3:0]  code_d, ramp_d;
    logic [10:0] vref_d;
    logic        pg_d, tri_d;
    logic [3:0]  code_q, ramp_q;
    logic [10:0] vref_q;
    logic        pg_q, tri_q, en_q, oc_q, bat_q, sdaoe_q;

    always_comb begin
        if (sel_s) begin
            code_d = {vb3_s, vb2_s, sda_s, scl_s};
        end else begin
            code_d = cmd_q[`CVC_VCODE_MSB:`CVC_VCODE_LSB];
        end
        vref_d = 11'(`CVC_VREF_BASE_MV + `CVC_VREF_STEP_MV * int'(code_d));
        ramp_d = slew_onehot(cmd_q[`CVC_SLEW_MSB:`CVC_SLEW_LSB]);
        pg_d   = en_s && !ov_if.flag && !uv_if.flag
                 && mem_s && pll_s;
        tri_d  = ov_if.flag || !en_s;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            code_q  <= `CVC_VCODE_DEF;
            ramp_q  <= 4'h2;
            vref_q  <= 11'h514;
            pg_q    <= 1'b0;
            tri_q   <= 1'b1;
            en_q    <= 1'b0;
            oc_q    <= 1'b0;
            bat_q   <= 1'b0;
            sdaoe_q <= 1'b0;
        end else begin
            code_q  <= code_d;
            ramp_q  <= ramp_d;
            vref_q  <= vref_d;
            pg_q    <= pg_d;
            tri_q   <= tri_d;
            en_q    <= en_s;
            oc_q    <= oc_s;
            bat_q   <= bat_if.flag;
            sdaoe_q <= oe_q && bus_on;
        end
    end

    // Open-drain pins only ever drive low
    assign sda_o               = 1'b0;
    assign sda_oe_o            = sdaoe_q;
    assign power_good_out_o    = 1'b0;
    assign power_good_out_oe_o = !pg_q;
    assign battery_fault_n_o   = bat_q;
    assign regs_enable_o       = en_q;
    assign phase_tristate_o    = tri_q;
    assign current_limit_o     = oc_q;
    assign ramp_src_sel_o      = ramp_q;
    assign dac_code_o          = code_q;
    assign vref_mv_o           = vref_q;
    assign cmd_reg_o           = {2'b00, cmd_q};
endmodule : cvc_top

`default_nettype wire

// *** core/cvc_consts.svh ***
// Purpose: Shared constants of the core voltage control block
// Assumes: 200 MHz system clock
// Notes:   Timing counts derive from the printed times and the clock period
`ifndef CVC_CONSTS_SVH
`define CVC_CONSTS_SVH

// Command byte layout
`define CVC_VCODE_MSB      3
`define CVC_VCODE_LSB      0
`define CVC_SLEW_MSB       5
`define CVC_SLEW_LSB       4
`define CVC_CMD_USED       6

// Reset values of the command fields
`define CVC_VCODE_DEF      4'h9
`define CVC_SLEW_DEF       2'h1

// Reference converter scale in millivolts
`define CVC_VREF_BASE_MV   850
`define CVC_VREF_STEP_MV   50

// Timing: overvoltage persistence, least time rounded up
`define CVC_CLK_PS         5000
`define CVC_OV_PERSIST_PS  1500000
`define CVC_OV_CYC         ((`CVC_OV_PERSIST_PS + `CVC_CLK_PS - 1) / `CVC_CLK_PS)
`define CVC_UV_CYC         1

// Bus framing
`define CVC_BITS_PER_BYTE  4'h8

`endif

// *** core/cvc_pkg.sv ***
// Purpose: Types of the core voltage control block
// Assumes: Constants come from cvc_consts.svh
// Notes:   Target state machine and slew code names
package cvc_pkg;

    typedef enum logic [1:0] {
        CVC_SLEW_5UA,
        CVC_SLEW_10UA,
        CVC_SLEW_25UA,
        CVC_SLEW_47UA
    } cvc_slew_t;

    typedef enum {
        CVC_ST_IDLE,
        CVC_ST_ADDR,
        CVC_ST_AACK,
        CVC_ST_WDAT,
        CVC_ST_WACK,
        CVC_ST_RDAT,
        CVC_ST_RACK,
        CVC_ST_SKIP
    } cvc_state_t;

endpackage : cvc_pkg

// *** core/cvc_hyst_if.sv ***
// Purpose: Carries set, clear and flag of one hysteresis monitor
// Assumes: All signals on clk_i of the top
// Notes:   One instance per monitored condition
`timescale 1ns/10ps
`default_nettype none

interface cvc_hyst_if;
    logic set;
    logic clr;
    logic flag;

    modport mon  (input set, input clr, output flag);
    modport user (output set, output clr, input flag);
endinterface : cvc_hyst_if

`default_nettype wire

// *** core/cvc_sync.sv ***
// Purpose: Two flip-flop synchroniser for a vector of asynchronous levels
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module cvc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    if (W < 1) begin : g_chk
        $error("cvc_sync: W must be at least 1");
    end

    // Next values
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Two stages
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : cvc_sync

`default_nettype wire

// *** core/cvc_hyst.sv ***
// Purpose: Set/clear flag with hysteresis and a set persistence count
// Assumes: set and clr are synchronous levels
// Notes:   Flag rises after set has held SET_CYC cycles; a set that has held that long wins over clr
`timescale 1ns/10ps
`default_nettype none

module cvc_hyst #(
    parameter int SET_CYC = 1
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    cvc_hyst_if.mon   mon
);
    localparam int CW = $clog2(SET_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          flag_q;
    logic          flag_d;

    if (SET_CYC < 1 || SET_CYC > 65535) begin : g_chk
        $error("cvc_hyst: SET_CYC out of range");
    end

    // Persistence counter and flag update
    always_comb begin
        cnt_d  = cnt_q;
        flag_d = flag_q;
        if (!mon.set) begin
            cnt_d = '0;
        end else if (cnt_q != CW'(SET_CYC)) begin
            cnt_d = cnt_q + 1'b1;
        end
        if (mon.set && cnt_q >= CW'(SET_CYC - 1)) begin
            flag_d = 1'b1;
        end else if (mon.clr) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q  <= '0;
            flag_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign mon.flag = flag_q;
endmodule : cvc_hyst

`default_nettype wire

// *** verification/cvc_top_monitor.sv ***
// Purpose: Port checks of the core voltage control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Counters replace long repetitions
`timescale 1ns/10ps
`default_nettype none

module cvc_top_monitor #(
    parameter int OV_CYC = 300
) (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        scl_i,
    input wire logic        sda_oe_o,
    input wire logic        code_source_select_i,
    input wire logic        enable_i,
    input wire logic        vout_over_set_i,
    input wire logic        vout_over_hold_i,
    input wire logic        vout_under_set_i,
    input wire logic        memory_ldo_ok_i,
    input wire logic        pll_ldo_ok_i,
    input wire logic        power_good_out_oe_o,
    input wire logic        regs_enable_o,
    input wire logic        phase_tristate_o,
    input wire logic [3:0]  ramp_src_sel_o,
    input wire logic [3:0]  dac_code_o,
    input wire logic [10:0] vref_mv_o,
    input wire logic [7:0]  cmd_reg_o
);
    logic [15:0] over_cnt_q, over_cnt_d, hold_lo_q, hold_lo_d;
    logic [1:0]  slew_w;
    logic [3:0]  vcode_w;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // Command fields
    assign slew_w  = cmd_reg_o[5:4];
    assign vcode_w = cmd_reg_o[3:0];

    // Saturating run lengths of set high, hold low
    always_comb begin
        over_cnt_d = vout_over_set_i ? over_cnt_q + 16'h1 : 16'h0;
        hold_lo_d  = vout_over_hold_i ? 16'h0 : hold_lo_q + 16'h1;
        if (&over_cnt_q) over_cnt_d = over_cnt_q;
        if (&hold_lo_q) hold_lo_d = hold_lo_q;
    end

    // Counter registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            over_cnt_q <= 16'h0;
            hold_lo_q  <= 16'h0;
        end else begin
            over_cnt_q <= over_cnt_d;
            hold_lo_q  <= hold_lo_d;
        end
    end

    // Steady enable and bus mode
    sequence s_en_steady;
        enable_i [*6];
    endsequence
    sequence s_bus_mode;
        !code_source_select_i [*6];
    endsequence

    a_ramp_one_hot: assert property ($onehot(ramp_src_sel_o))
        else $error("ramp not one-hot");
    a_ramp_follows: assert property (ramp_src_sel_o == 4'(4'h1 << $past(slew_w)))
        else $error("ramp vs slew");
    a_dac_follows: assert property (s_bus_mode |-> dac_code_o == $past(vcode_w))
        else $error("code vs command");
    a_vref_scale: assert property (vref_mv_o == 11'h352 + 11'h032 * dac_code_o)
        else $error("reference scale");
    a_pins_mode_quiet: assert property (code_source_select_i [*4] |-> !sda_oe_o)
        else $error("data driven in pin mode");
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed while clock high");
    a_enable_all: assert property (enable_i [*4] |-> regs_enable_o)
        else $error("regulators not enabled");
    a_ov_trip: assert property (s_en_steady ##0 $rose(phase_tristate_o)
        |-> over_cnt_q >= OV_CYC)
        else $error("early overvoltage");
    a_ov_sets: assert property (s_en_steady ##0 (over_cnt_q >= OV_CYC + 5)
        |-> phase_tristate_o)
        else $error("overvoltage not flagged");
    a_ov_clear: assert property (s_en_steady ##0 $fell(phase_tristate_o)
        |-> hold_lo_q >= 16'h2)
        else $error("overvoltage cleared early");
    a_pg_drop: assert property ((!memory_ldo_ok_i || !pll_ldo_ok_i || vout_under_set_i) [*5]
        |-> power_good_out_oe_o)
        else $error("power good during fault");
endmodule : cvc_top_monitor

bind cvc_top cvc_top_monitor #(.OV_CYC(OV_CYC)) i_cvc_top_monitor (
    .clk_i, .srst_i, .scl_i, .sda_oe_o, .code_source_select_i, .enable_i,
    .vout_over_set_i, .vout_over_hold_i, .vout_under_set_i, .memory_ldo_ok_i,
    .pll_ldo_ok_i, .power_good_out_oe_o, .regs_enable_o, .phase_tristate_o,
    .ramp_src_sel_o, .dac_code_o, .vref_mv_o, .cmd_reg_o);

`default_nettype wire

// *** verification/cvc_ctrl_model.sv ***
// Purpose: Bus controller model framing transfers on SCL and SDA
// Assumes: Steps on the bench clock falling edge, 25 clocks per bit (125 ns)
// Notes:   Open drain; clock stands high between frames
`timescale 1ns/10ps
`default_nettype none

module cvc_ctrl_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    // Both lines released at time zero
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // One bit: data set in low phase, sampled mid-high
    task automatic bit_x(input logic b, output logic got);
        sda_low_o = !b;
        tick(6);
        scl_o = 1'b1;
        tick(6);
        got = sda_i;
        tick(7);
        scl_o = 1'b0;
        tick(6);
    endtask : bit_x

    // Data falls while clock high; also serves as a repeated start
    task automatic start_c();
        sda_low_o = 1'b0;
        tick(6);
        scl_o = 1'b1;
        tick(12);
        sda_low_o = 1'b1;
        tick(12);
        scl_o = 1'b0;
        tick(1);
    endtask : start_c

    // Data released to rise while clock high
    task automatic stop_c();
        sda_low_o = 1'b1;
        tick(6);
        scl_o = 1'b1;
        tick(12);
        sda_low_o = 1'b0;
        tick(12);
    endtask : stop_c

    // Eight bits MSB first, then ack slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(d[i], g);
        bit_x(1'b1, g);
        ack = !g;
    endtask : send_byte

    // Eight bits in, then ack or not-ack
    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!mack, g);
    endtask : recv_byte

    // Static levels for pin-code mode
    task automatic set_pins(input logic c, input logic d);
        scl_o     = c;
        sda_low_o = !d;
    endtask : set_pins
endmodule : cvc_ctrl_model

`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the core voltage control block
// Assumes: Model frames bus traffic
// Notes:   Overvoltage persistence shortened to OV_N cycles
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam logic [6:0] ADDR = 7'h2A;
    localparam int         OV_N = 4;
    typedef struct packed {
        logic [7:0]  d;
        logic [7:0]  cmd;
        logic [3:0]  ramp;
        logic [10:0] vref;
    } cvc_tb_row_t;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        scl, sda, ctl_low, b2, b3, sel, en, ov_s, ov_h, uv_s, uv_h, oc, ok;
    logic        mok, pok, bhi, blo, sda_oe, pg_oe, bfn, ren, ptri, clim;
    logic [3:0]  ramp, dac;
    logic [10:0] vref;
    logic [7:0]  cmd, rb;
    int          error_cnt = 0;
    int          num_checks = 0;
    cvc_tb_row_t rows [4] = '{'{8'h00, 8'h00, 4'h1, 11'h352}, '{8'h1F, 8'h1F, 4'h2, 11'h640},
                              '{8'hE5, 8'h25, 4'h4, 11'h44C}, '{8'h3A, 8'h3A, 4'h8, 11'h546}};

    // Clock and the pulled-up data wire
    always #2.5 clk_i = ~clk_i;
    assign sda = !(sda_oe | ctl_low);

    cvc_top #(.TGT_ADDR(ADDR), .OV_CYC(OV_N)) i_cvc_top (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .vcode_b2_i(b2), .vcode_b3_i(b3), .code_source_select_i(sel),
        .enable_i(en), .vout_over_set_i(ov_s), .vout_over_hold_i(ov_h),
        .vout_under_set_i(uv_s), .vout_under_hold_i(uv_h), .overcurrent_i(oc),
        .memory_ldo_ok_i(mok), .pll_ldo_ok_i(pok), .batt_above_hi_i(bhi),
        .batt_below_lo_i(blo), .power_good_out_o(), .power_good_out_oe_o(pg_oe),
        .battery_fault_n_o(bfn), .regs_enable_o(ren), .phase_tristate_o(ptri),
        .current_limit_o(clim), .ramp_src_sel_o(ramp), .dac_code_o(dac),
        .vref_mv_o(vref), .cmd_reg_o(cmd));
    cvc_ctrl_model i_cvc_ctrl_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(ctl_low));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_clk

    // Addressed frame: start, address with direction, no stop
    task automatic open_f(input logic rw);
        i_cvc_ctrl_model.start_c();
        i_cvc_ctrl_model.send_byte({ADDR, rw}, ok);
        check(ok, 1'b1);
    endtask : open_f

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end

    // Reset, table rows, awkward cases
    initial begin
        {b2, b3, sel, ov_s, ov_h, uv_s, uv_h, oc, blo} = '0;
        {en, mok, pok, bhi} = '1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        check({cmd, ramp, vref, sda_oe}, {8'h19, 4'h2, 11'h514, 1'b0});
        srst_i = 1'b0;
        wait_clk(10);
        check({pg_oe, bfn, ren}, 3'b011);
        foreach (rows[i]) begin
            open_f(1'b0);
            i_cvc_ctrl_model.send_byte(rows[i].d, ok);
            i_cvc_ctrl_model.stop_c();
            check({ok, cmd, ramp, vref}, {1'b1, rows[i].cmd, rows[i].ramp, rows[i].vref});
            open_f(1'b1);
            i_cvc_ctrl_model.recv_byte(1'b0, rb);
            i_cvc_ctrl_model.stop_c();
            check(rb, rows[i].cmd);
        end
        // Foreign address, then repeated start
        i_cvc_ctrl_model.start_c();
        i_cvc_ctrl_model.send_byte({ADDR ^ 7'h01, 1'b0}, ok);
        check(ok, 1'b0);
        i_cvc_ctrl_model.send_byte(8'h07, ok);
        check({ok, cmd}, {1'b0, 8'h3A});
        open_f(1'b0);
        i_cvc_ctrl_model.send_byte(8'h12, ok);
        check(cmd, 8'h12);
        i_cvc_ctrl_model.send_byte(8'h2B, ok);
        check({ok, cmd}, {1'b1, 8'h2B});
        open_f(1'b1);
        i_cvc_ctrl_model.recv_byte(1'b1, rb);
        check(rb, 8'h2B);
        i_cvc_ctrl_model.recv_byte(1'b0, rb);
        i_cvc_ctrl_model.stop_c();
        check(rb, 8'h2B);
        // Disable keeps the set-point
        en = 1'b0;
        wait_clk(8);
        check({ren, ptri, pg_oe}, 3'b011);
        en = 1'b1;
        wait_clk(8);
        check({ren, ptri, dac, cmd}, {2'b10, 4'hB, 8'h2B});
        // Pin-code mode
        sel = 1'b1;
        b3 = 1'b1;
        i_cvc_ctrl_model.set_pins(1'b0, 1'b1);
        wait_clk(8);
        check({dac, vref, sda_oe}, {4'hA, 11'h546, 1'b0});
        i_cvc_ctrl_model.set_pins(1'b1, 1'b1);
        wait_clk(2);
        {sel, b3} = 2'b00;
        wait_clk(8);
        check(dac, 4'hB);
        // Overvoltage: short, held, hysteresis
        {ov_h, ov_s} = 2'b11;
        wait_clk(OV_N - 1);
        ov_s = 1'b0;
        wait_clk(6);
        check(ptri, 1'b0);
        ov_s = 1'b1;
        wait_clk(OV_N + 6);
        ov_s = 1'b0;
        check({ptri, pg_oe}, 2'b11);
        wait_clk(8);
        check(ptri, 1'b1);
        ov_h = 1'b0;
        wait_clk(6);
        check({ptri, pg_oe}, 2'b00);
        // Undervoltage with overcurrent
        {uv_h, uv_s, oc} = 3'b111;
        wait_clk(6);
        check({pg_oe, clim}, 2'b11);
        {uv_s, oc} = 2'b00;
        wait_clk(6);
        check({pg_oe, clim}, 2'b10);
        uv_h = 1'b0;
        wait_clk(6);
        check(pg_oe, 1'b0);
        // Battery and regulator tolerance
        {bhi, mok} = 2'b00;
        wait_clk(6);
        check({bfn, pg_oe}, 2'b11);
        {blo, mok, pok} = 3'b110;
        wait_clk(6);
        check({bfn, pg_oe}, 2'b01);
        {blo, pok} = 2'b01;
        wait_clk(6);
        check({bfn, pg_oe}, 2'b00);
        bhi = 1'b1;
        wait_clk(6);
        check(bfn, 1'b1);
        // Second reset in mid-run
        srst_i = 1'b1;
        wait_clk(5);
        check({cmd, ramp}, {8'h19, 4'h2});
        srst_i = 1'b0;
        wait_clk(6);
        close_out();
    end
endmodule : testbench

`default_nettype wire
